// File: shared/bis_defines.svh
// offsets, field positions and reset values of the interrupt source block
// assumes a byte-addressed register port with 8-bit addresses
`ifndef BIS_DEFINES_SVH
`define BIS_DEFINES_SVH
`define BIS_OFF_LEN     8'h00
`define BIS_OFF_LSTAT   8'h04
`define BIS_OFF_LMAP2   8'h08
`define BIS_OFF_LMAP3   8'h0C
`define BIS_OFF_VEN     8'h10
`define BIS_OFF_VSTAT   8'h14
`define BIS_OFF_VMAP3   8'h18
`define BIS_OFF_MCTL    8'h1C
`define BIS_OFF_LMBASE  8'h20
`define BIS_OFF_LMCTL   8'h24
`define BIS_OFF_DCTL    8'h28
`define BIS_OFF_DSTAT   8'h2C
`define BIS_OFF_SWV     8'h30
`define BIS_SRC_SACK    0
`define BIS_SRC_OWN     1
`define BIS_SRC_DMA     2
`define BIS_SRC_MBX     3
`define BIS_SRC_LM      7
`define BIS_SRC_PERR    11
`define BIS_SRC_VERR    12
`define BIS_NSRC        13
`define BIS_NVSRC       7
`define BIS_DCTL_LINK   8
`define BIS_DCTL_GO     9
`define BIS_STATID_AUTO 8'hFE
`define BIS_AUTO_LEVEL  3'h2
`define BIS_RST_WORD    32'h0000_0000
`endif

// File: shared/bis_pkg.sv
// types shared by the interrupt source block
// assumes nothing beyond the defines header
package bis_pkg;
	typedef enum logic [2:0] {
		BIS_DMA_IDLE  = 3'b001,
		BIS_DMA_RUN   = 3'b010,
		BIS_DMA_FETCH = 3'b100
	} bis_dma_st_t;
endpackage : bis_pkg

// File: hdl/bis_core.sv
// internal interrupt sources of the bus bridge: enable, map, log
// assumes all event inputs are pulses from logic on clk
`timescale 1ns/1ps
`include "bis_defines.svh"
module bis_core
	import bis_pkg::*;
#(
	parameter logic [7:0] STATID_BASE = 8'hA0 // arbitrary
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        autoid_strap,
	input  wire logic        iack_req,
	input  wire logic [2:0]  iack_level,
	output logic             iack_ack,
	output logic      [7:0]  iack_statid,
	input  wire logic        vme_grant,
	input  wire logic [3:0]  mbox_access,
	input  wire logic        slv_valid,
	input  wire logic [31:0] slv_addr,
	input  wire logic [1:0]  slv_space,
	input  wire logic        pci_abort,
	input  wire logic        vme_berr,
	input  wire logic        err_posted,
	input  wire logic [5:0]  dma_cause,
	input  wire logic        dma_pkt_done,
	input  wire logic        dma_last_pkt,
	input  wire logic        dma_fetch_done,
	output logic      [3:0]  pci_irq_out_lines,
	output logic      [7:1]  vme_irq_lines,
	output logic             vme_req,
	output logic             crcsr_enable,
	output logic             sysfail_assert,
	output logic             dma_fetch_req,
	output logic             dma_busy
);

	// ****************************************
	// registers
	// ****************************************
	logic [12:0] local_irq_enable_reg_q;
	logic [12:0] local_irq_status_reg_q;
	logic [14:0] local_irq_map_second_q;
	logic [23:0] local_irq_map_third_q;
	logic [6:0]  vme_en_q;
	logic [6:0]  vme_irq_status_reg_q;
	logic [20:0] vme_irq_map_third_q;
	logic        bus_hold_request_bit_q;
	logic [19:0] monitor_base_address_q;
	logic [1:0]  lm_space_q;
	logic        lm_en_q;
	logic [5:0]  dma_en_q;
	logic        dma_link_q;
	logic [5:0]  dma_stat_q;
	logic        swv_bit_q;
	logic [2:0]  swv_lvl_q;
	logic        swv_pend_q;
	logic        auto_pend_q;
	logic        auto_on_q;
	logic        grant_q;
	logic [1:0]  strap_sync_q;
	bis_dma_st_t dma_st_q;
	bis_dma_st_t dma_st_d;

	logic        wr_lstat, wr_vstat, wr_dctl, wr_swv, wr_dstat;
	logic [12:0] set_l;
	logic [6:0]  set_v;
	logic [3:0]  lm_hit;
	logic        sack_ev;
	logic        dma_any;
	logic        auto_serve, sw_serve, oth_serve;
	logic [38:0] lmap;
	logic [3:0]  lsel [13];
	logic [7:1]  vsel [7];
	logic [3:0]  pci_d;
	logic [7:1]  vme_d;
	logic [31:0] rd_d;

	assign wr_lstat = reg_wr && reg_addr == `BIS_OFF_LSTAT;
	assign wr_vstat = reg_wr && reg_addr == `BIS_OFF_VSTAT;
	assign wr_dctl  = reg_wr && reg_addr == `BIS_OFF_DCTL;
	assign wr_dstat = reg_wr && reg_addr == `BIS_OFF_DSTAT;
	assign wr_swv   = reg_wr && reg_addr == `BIS_OFF_SWV;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			local_irq_enable_reg_q <= 13'h0000;
			local_irq_map_second_q <= 15'h0000;
			local_irq_map_third_q  <= 24'h000000;
			vme_en_q               <= 7'h00;
			vme_irq_map_third_q    <= 21'h000000;
			bus_hold_request_bit_q <= 1'b0;
			monitor_base_address_q <= 20'h00000;
			lm_space_q             <= 2'h0;
			lm_en_q                <= 1'b0;
			dma_en_q               <= 6'h00;
			dma_link_q             <= 1'b0;
		end else if (reg_wr) begin
			case (reg_addr)
			`BIS_OFF_LEN:    local_irq_enable_reg_q <= reg_wdata[12:0];
			`BIS_OFF_LMAP2:  local_irq_map_second_q <= reg_wdata[14:0];
			`BIS_OFF_LMAP3:  local_irq_map_third_q  <= reg_wdata[23:0];
			`BIS_OFF_VEN:    vme_en_q               <= reg_wdata[6:0];
			`BIS_OFF_VMAP3:  vme_irq_map_third_q    <= reg_wdata[20:0];
			`BIS_OFF_MCTL:   bus_hold_request_bit_q <= reg_wdata[0];
			`BIS_OFF_LMBASE: monitor_base_address_q <= reg_wdata[31:12];
			`BIS_OFF_LMCTL: begin
				lm_space_q <= reg_wdata[1:0];
				lm_en_q    <= reg_wdata[2];
			end
			`BIS_OFF_DCTL: begin
				dma_en_q   <= reg_wdata[5:0];
				dma_link_q <= reg_wdata[`BIS_DCTL_LINK];
			end
			default: ;
			endcase
		end
	end

	// ****************************************
	// event sources
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lm
			assign lm_hit[g] = slv_valid && lm_en_q &&
				slv_addr[31:12] == monitor_base_address_q &&
				slv_space == lm_space_q &&
				slv_addr[4:3] == 2'(g);
		end
	endgenerate

	assign dma_any = |(dma_stat_q & dma_en_q);
	assign set_l[`BIS_SRC_SACK] = sack_ev;
	assign set_l[`BIS_SRC_OWN] = bus_hold_request_bit_q && vme_grant &&
		!grant_q;
	assign set_l[`BIS_SRC_DMA] = dma_any;
	assign set_l[`BIS_SRC_MBX +: 4] = mbox_access;
	assign set_l[`BIS_SRC_LM +: 4] = lm_hit;
	assign set_l[`BIS_SRC_PERR] = pci_abort && err_posted;
	assign set_l[`BIS_SRC_VERR] = vme_berr && err_posted;
	assign set_v = {set_l[`BIS_SRC_VERR], set_l[`BIS_SRC_PERR], dma_any,
		mbox_access};

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) grant_q <= 1'b0;
		else grant_q <= vme_grant;
	end

	// set beats a same-cycle write-one-to-clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			local_irq_status_reg_q <= 13'h0000;
		end else begin
			local_irq_status_reg_q <= (local_irq_status_reg_q &
				~(wr_lstat ? reg_wdata[12:0] : 13'h0000)) | set_l;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			vme_irq_status_reg_q <= 7'h00;
		end else begin
			vme_irq_status_reg_q <= (vme_irq_status_reg_q &
				~(wr_vstat ? reg_wdata[6:0] : 7'h00)) | set_v;
		end
	end

	// six causes kept apart so the host can tell them apart
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dma_stat_q <= 6'h00;
		end else begin
			dma_stat_q <= (dma_stat_q &
				~(wr_dstat ? reg_wdata[5:0] : 6'h00)) | dma_cause;
		end
	end

	// ****************************************
	// dma sequencer
	// ****************************************
	always_comb begin
		dma_st_d = dma_st_q;
		case (dma_st_q)
		BIS_DMA_IDLE:
			if (wr_dctl && reg_wdata[`BIS_DCTL_GO]) dma_st_d = BIS_DMA_RUN;
		BIS_DMA_RUN:
			if (|dma_cause[2:0]) dma_st_d = BIS_DMA_IDLE;
			else if (dma_pkt_done && dma_link_q && !dma_last_pkt)
				dma_st_d = BIS_DMA_FETCH;
			else if (dma_pkt_done) dma_st_d = BIS_DMA_IDLE;
		BIS_DMA_FETCH:
			if (dma_fetch_done) dma_st_d = BIS_DMA_RUN;
		default: dma_st_d = BIS_DMA_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) dma_st_q <= BIS_DMA_IDLE;
		else dma_st_q <= dma_st_d;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dma_fetch_req <= 1'b0;
			dma_busy      <= 1'b0;
		end else begin
			dma_fetch_req <= dma_st_d == BIS_DMA_FETCH;
			dma_busy      <= dma_st_d != BIS_DMA_IDLE;
		end
	end

	// ****************************************
	// vme soft interrupt, auto-id, ack cycle
	// ****************************************
	assign auto_serve = iack_req && auto_pend_q &&
		iack_level == `BIS_AUTO_LEVEL;
	assign sw_serve = iack_req && !auto_serve && swv_pend_q &&
		iack_level == swv_lvl_q;
	assign oth_serve = iack_req && !auto_serve && !sw_serve &&
		iack_level != 3'h0 && vme_d[iack_level];
	assign sack_ev = sw_serve;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			swv_bit_q  <= 1'b0;
			swv_lvl_q  <= 3'h0;
			swv_pend_q <= 1'b0;
		end else begin
			if (wr_swv) begin
				swv_bit_q <= reg_wdata[0];
				swv_lvl_q <= reg_wdata[3:1];
			end
			// edge triggered; clearing the bit withdraws it
			if (wr_swv && reg_wdata[0] && !swv_bit_q &&
					reg_wdata[3:1] != 3'h0)
				swv_pend_q <= 1'b1;
			else if (sw_serve || (wr_swv && !reg_wdata[0]))
				swv_pend_q <= 1'b0;
		end
	end

	// no reset: the strap is through both stages by release
	always_ff @(posedge clk) begin
		strap_sync_q <= {strap_sync_q[0], autoid_strap};
	end

	// strap caught on the first clocked edge after release
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			auto_on_q      <= 1'b0;
			auto_pend_q    <= 1'b0;
			sysfail_assert <= 1'b1;
			crcsr_enable   <= 1'b0;
		end else begin
			if (!auto_on_q) begin
				auto_on_q   <= 1'b1;
				auto_pend_q <= strap_sync_q[1];
			end else if (auto_serve) begin
				auto_pend_q  <= 1'b0;
				crcsr_enable <= 1'b1;
			end
			// release once the level 2 request is on the bus, or at once when no auto-id is pending
			if (auto_on_q && (!auto_pend_q || vme_irq_lines[2]))
				sysfail_assert <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			iack_ack    <= 1'b0;
			iack_statid <= 8'h00;
		end else begin
			iack_ack <= auto_serve || sw_serve || oth_serve;
			if (auto_serve) iack_statid <= `BIS_STATID_AUTO;
			else if (sw_serve) iack_statid <= {STATID_BASE[7:1], 1'b0};
			else if (oth_serve) iack_statid <= {STATID_BASE[7:1], 1'b1};
		end
	end

	// ****************************************
	// line mapping: code 1xx leaves a pci source unmapped, code 0 a vme source
	// ****************************************
	assign lmap = {local_irq_map_third_q, local_irq_map_second_q};

	generate
		for (g = 0; g < `BIS_NSRC; g++) begin : g_lsrc
			localparam int M = (g < 3) ? g : (g >= 11) ? g - 8 : g + 2;
			assign lsel[g] = (local_irq_status_reg_q[g] &&
				local_irq_enable_reg_q[g] && !lmap[M*3+2]) ?
				4'h1 << lmap[M*3 +: 2] : 4'h0;
		end
		for (g = 0; g < `BIS_NVSRC; g++) begin : g_vsrc
			assign vsel[g] = (vme_irq_status_reg_q[g] && vme_en_q[g] &&
				vme_irq_map_third_q[g*3 +: 3] != 3'h0) ?
				7'(8'h01 << vme_irq_map_third_q[g*3 +: 3] >> 1) :
				7'h00;
		end
	endgenerate

	always_comb begin
		pci_d = 4'h0;
		vme_d = 7'h00;
		for (int i = 0; i < `BIS_NSRC; i++) pci_d = pci_d | lsel[i];
		for (int i = 0; i < `BIS_NVSRC; i++) vme_d = vme_d | vsel[i];
		if (swv_pend_q) vme_d = vme_d | 7'(8'h01 << swv_lvl_q >> 1);
		if (auto_pend_q) vme_d[2] = 1'b1;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pci_irq_out_lines <= 4'h0;
			vme_irq_lines     <= 7'h00;
			vme_req           <= 1'b0;
		end else begin
			pci_irq_out_lines <= pci_d;
			vme_irq_lines     <= vme_d;
			vme_req           <= bus_hold_request_bit_q;
		end
	end

	// ****************************************
	// read port
	// ****************************************
	always_comb begin
		rd_d = `BIS_RST_WORD;
		case (reg_addr)
		`BIS_OFF_LEN:    rd_d[12:0] = local_irq_enable_reg_q;
		`BIS_OFF_LSTAT:  rd_d[12:0] = local_irq_status_reg_q;
		`BIS_OFF_LMAP2:  rd_d[14:0] = local_irq_map_second_q;
		`BIS_OFF_LMAP3:  rd_d[23:0] = local_irq_map_third_q;
		`BIS_OFF_VEN:    rd_d[6:0]  = vme_en_q;
		`BIS_OFF_VSTAT:  rd_d[9:0]  = {auto_pend_q, swv_pend_q, 1'b0,
			vme_irq_status_reg_q};
		`BIS_OFF_VMAP3:  rd_d[20:0] = vme_irq_map_third_q;
		`BIS_OFF_MCTL:   rd_d[1:0]  = {vme_grant, bus_hold_request_bit_q};
		`BIS_OFF_LMBASE: rd_d[31:12] = monitor_base_address_q;
		`BIS_OFF_LMCTL:  rd_d[2:0]  = {lm_en_q, lm_space_q};
		`BIS_OFF_DCTL:   rd_d[8:0]  = {dma_link_q, 2'h0, dma_en_q};
		`BIS_OFF_DSTAT:  rd_d[10:0] = {dma_st_q, 2'h0, dma_stat_q};
		`BIS_OFF_SWV:    rd_d[3:0]  = {swv_lvl_q, swv_bit_q};
		default:         rd_d = `BIS_RST_WORD;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) reg_rdata <= `BIS_RST_WORD;
		else if (reg_rd) reg_rdata <= rd_d;
		else reg_rdata <= `BIS_RST_WORD;
	end

	// ****************************************
	// assertions
	// ****************************************
	property p_sack;
		@(posedge clk) disable iff (sys_rst)
		sw_serve |=> local_irq_status_reg_q[0];
	endproperty
	a_sack: assert property (p_sack) else $error("soft ack not logged");

	property p_own;
		@(posedge clk) disable iff (sys_rst)
		wr_lstat && reg_wdata[1] && !set_l[1] |=> !local_irq_status_reg_q[1];
	endproperty
	a_own: assert property (p_own) else $error("ownership not cleared");

	property p_own_set;
		@(posedge clk) disable iff (sys_rst)
		$rose(vme_grant) && bus_hold_request_bit_q |=>
			local_irq_status_reg_q[1];
	endproperty
	a_own_set: assert property (p_own_set) else $error("own lost");

	property p_err;
		@(posedge clk) disable iff (sys_rst)
		!err_posted |-> set_l[12:11] == 2'h0;
	endproperty
	a_err: assert property (p_err) else $error("error not posted");

	property p_lm;
		@(posedge clk) disable iff (sys_rst)
		lm_hit != 4'h0 |-> lm_en_q && $onehot(lm_hit) &&
			lm_hit[slv_addr[4:3]];
	endproperty
	a_lm: assert property (p_lm) else $error("monitor select wrong");

	property p_auto;
		@(posedge clk) disable iff (sys_rst)
		auto_serve |=> iack_ack && iack_statid == 8'hFE && crcsr_enable;
	endproperty
	a_auto: assert property (p_auto) else $error("auto-id answer wrong");

	property p_sw;
		@(posedge clk) disable iff (sys_rst)
		sw_serve |=> iack_ack && !iack_statid[0] && !swv_pend_q;
	endproperty
	a_sw: assert property (p_sw) else $error("soft ack answer wrong");

	property p_line;
		@(posedge clk) disable iff (sys_rst)
		local_irq_enable_reg_q == 13'h0000 ##1
			local_irq_enable_reg_q == 13'h0000 |=>
			pci_irq_out_lines == 4'h0;
	endproperty
	a_line: assert property (p_line) else $error("line without source");

	property p_fetch;
		@(posedge clk) disable iff (sys_rst)
		dma_st_q == BIS_DMA_RUN && dma_pkt_done && dma_link_q &&
			!dma_last_pkt && dma_cause[2:0] == 3'h0 |=> ##1 dma_fetch_req;
	endproperty
	a_fetch: assert property (p_fetch) else $error("no packet fetch");

	c_auto: cover property (@(posedge clk) disable iff (sys_rst) auto_serve);
	c_sw:   cover property (@(posedge clk) disable iff (sys_rst) sw_serve);
	c_lm:   cover property (@(posedge clk) disable iff (sys_rst) |lm_hit);

endmodule : bis_core

// File: verif/bis_far_end.sv
// far-side model: vme interrupt handler with monarch role, and bus arbiter
// assumes the block's outputs are registered on the same clock
`timescale 1ns/1ps
`include "bis_defines.svh"
module bis_far_end
	import bis_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       handler_en,
	input  wire logic [3:0] grant_dly,
	input  wire logic [7:1] vme_irq_lines,
	input  wire logic       iack_ack,
	input  wire logic [7:0] iack_statid,
	input  wire logic       vme_req,
	output logic            iack_req,
	output logic      [2:0] iack_level,
	output logic            vme_grant,
	output logic            monarch_found
);
	// ****************************************
	// interrupt handler
	// ****************************************
	logic [3:0] hold_q;
	logic [3:0] gcnt_q;

	function automatic logic [2:0] top_level(input logic [7:1] l);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 1; i < 8; i++) begin
			if (l[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction : top_level

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			iack_req      <= 1'b0;
			iack_level    <= 3'h0;
			hold_q        <= 4'h0;
			monarch_found <= 1'b0;
		end else begin
			iack_req <= 1'b0;
			// idle level keeps moving so a stale value never passes
			iack_level <= ~iack_level;
			if (hold_q != 4'h0) begin
				hold_q <= hold_q - 4'h1;
			end else if (handler_en && vme_irq_lines != 7'h00) begin
				iack_req   <= 1'b1;
				iack_level <= top_level(vme_irq_lines);
				hold_q     <= 4'h8;
			end
			if (iack_ack && iack_statid == `BIS_STATID_AUTO) begin
				monarch_found <= 1'b1;
			end
		end
	end

	// ****************************************
	// arbiter, prompt or slow by grant_dly
	// ****************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			vme_grant <= 1'b0;
			gcnt_q    <= 4'h0;
		end else if (!vme_req) begin
			vme_grant <= 1'b0;
			gcnt_q    <= 4'h0;
		end else if (gcnt_q >= grant_dly) begin
			vme_grant <= 1'b1;
		end else begin
			gcnt_q <= gcnt_q + 4'h1;
		end
	end
endmodule : bis_far_end

// File: verif/bis_core_bench.sv
// self-checking bench of the interrupt source block
// assumes the far-side model answers ack cycles and bus requests
`timescale 1ns/1ps
`include "bis_defines.svh"
`define CHK(g, e) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("[ERR] %0t got %0h exp %0h", $time, g, e); \
	end \
end
`define PULSE(s, v) begin \
	@(posedge clk); \
	s <= v; \
	@(posedge clk); \
	s <= '0; \
end
module bis_core_bench
	import bis_pkg::*;
;
	localparam logic [7:0] SB = 8'h5C; // arbitrary
	logic        clk, sys_rst, reg_wr, reg_rd, autoid_strap, iack_req;
	logic        iack_ack, vme_grant, slv_valid, pci_abort, vme_berr;
	logic        err_posted, dma_pkt_done, dma_last_pkt, dma_fetch_done;
	logic        vme_req, crcsr_enable, sysfail_assert, dma_fetch_req;
	logic        dma_busy, handler_en, monarch_found;
	logic [1:0]  slv_space;
	logic [2:0]  iack_level;
	logic [3:0]  mbox_access, pci_irq_out_lines, grant_dly;
	logic [5:0]  dma_cause;
	logic [7:0]  reg_addr, iack_statid;
	logic [7:1]  vme_irq_lines;
	logic [31:0] reg_wdata, reg_rdata, slv_addr, rdv;
	int          fails, samples_checked;

	bis_core #(.STATID_BASE(SB)) bis_core_i (
		.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .autoid_strap(autoid_strap),
		.iack_req(iack_req), .iack_level(iack_level), .iack_ack(iack_ack),
		.iack_statid(iack_statid), .vme_grant(vme_grant),
		.mbox_access(mbox_access), .slv_valid(slv_valid),
		.slv_addr(slv_addr), .slv_space(slv_space), .pci_abort(pci_abort),
		.vme_berr(vme_berr), .err_posted(err_posted),
		.dma_cause(dma_cause), .dma_pkt_done(dma_pkt_done),
		.dma_last_pkt(dma_last_pkt), .dma_fetch_done(dma_fetch_done),
		.pci_irq_out_lines(pci_irq_out_lines),
		.vme_irq_lines(vme_irq_lines), .vme_req(vme_req),
		.crcsr_enable(crcsr_enable), .sysfail_assert(sysfail_assert),
		.dma_fetch_req(dma_fetch_req), .dma_busy(dma_busy)
	);
	bis_far_end bis_far_end_i (
		.clk(clk), .sys_rst(sys_rst), .handler_en(handler_en),
		.grant_dly(grant_dly), .vme_irq_lines(vme_irq_lines),
		.iack_ack(iack_ack), .iack_statid(iack_statid), .vme_req(vme_req),
		.iack_req(iack_req), .iack_level(iack_level),
		.vme_grant(vme_grant), .monarch_found(monarch_found)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ****************************************
	// bus cycles and waits
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		rdv = reg_rdata;
	endtask : rd

	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask : settle

	task automatic wait_hi(input int sel);
		for (int i = 0; i < 300; i++) begin
			@(posedge clk);
			#1;
			if ((sel == 0 && iack_ack === 1'b1) ||
				(sel == 1 && vme_grant === 1'b1) ||
				(sel == 2 && vme_irq_lines[2] === 1'b1)) return;
		end
		fails++;
		$display("[ERR] %0t wait ran out", $time);
		print_verdict();
	endtask : wait_hi

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_autoid();
		wait_hi(2);
		`CHK(sysfail_assert, 1'b1)
		@(posedge clk);
		#1;
		`CHK(sysfail_assert, 1'b0)
		rd(`BIS_OFF_LEN);
		`CHK(rdv, `BIS_RST_WORD)
		handler_en <= 1'b1;
		wait_hi(0);
		`CHK(iack_statid, `BIS_STATID_AUTO)
		settle();
		handler_en <= 1'b0;
		`CHK({crcsr_enable, vme_irq_lines[2]}, 2'b10)
		`CHK(monarch_found, 1'b1)
	endtask : t_autoid

	// soft vme interrupt shares level 3 with mailbox 2
	task automatic t_soft();
		wr(`BIS_OFF_LMAP2, 32'h0000_4688);
		wr(`BIS_OFF_LMAP3, 32'h0068_88E4);
		wr(`BIS_OFF_VMAP3, 32'h0018_00C0);
		wr(`BIS_OFF_LEN, 32'h0000_0021);
		wr(`BIS_OFF_VEN, 32'h0000_0044);
		`PULSE(mbox_access, 4'h5)
		wr(`BIS_OFF_SWV, 32'h0000_0007);
		settle();
		`CHK({pci_irq_out_lines, vme_irq_lines}, 11'h404)
		rd(`BIS_OFF_VSTAT);
		`CHK(rdv[9:0], 10'h105)
		rd(`BIS_OFF_LSTAT);
		`CHK(rdv[12:0], 13'h0028)
		handler_en <= 1'b1;
		wait_hi(0);
		`CHK(iack_statid, {SB[7:1], 1'b0})
		settle();
		`CHK({pci_irq_out_lines, vme_irq_lines}, 11'h484)
		rd(`BIS_OFF_VSTAT);
		`CHK(rdv[9:8], 2'b00)
		wait_hi(0);
		handler_en <= 1'b0;
		`CHK(iack_statid, {SB[7:1], 1'b1})
		wr(`BIS_OFF_LSTAT, 32'h0000_0001);
		settle();
		`CHK(pci_irq_out_lines, 4'h8)
		wr(`BIS_OFF_SWV, 32'h0000_0000);
		wr(`BIS_OFF_LSTAT, 32'h0000_1FFF);
		wr(`BIS_OFF_VSTAT, 32'h0000_007F);
		settle();
		`CHK({pci_irq_out_lines, vme_irq_lines}, 11'h000)
	endtask : t_soft

	task automatic t_own(input logic [3:0] dly);
		grant_dly <= dly;
		wr(`BIS_OFF_LEN, 32'h0000_0002);
		wr(`BIS_OFF_MCTL, 32'h0000_0001);
		wait_hi(1);
		settle();
		`CHK({vme_req, pci_irq_out_lines}, 5'h12)
		rd(`BIS_OFF_LSTAT);
		`CHK(rdv[1], 1'b1)
		wr(`BIS_OFF_MCTL, 32'h0000_0000);
		wr(`BIS_OFF_LSTAT, 32'h0000_0002);
		settle();
		`CHK(pci_irq_out_lines, 4'h0)
	endtask : t_own

	task automatic t_dma();
		wr(`BIS_OFF_LEN, 32'h0000_0004);
		wr(`BIS_OFF_DCTL, 32'h0000_003F);
		for (int i = 0; i < 6; i++) begin
			`PULSE(dma_cause, 6'(1 << i))
			settle();
			`CHK(pci_irq_out_lines, 4'h4)
			rd(`BIS_OFF_DSTAT);
			`CHK(rdv[5:0], 6'(1 << i))
			wr(`BIS_OFF_DSTAT, 32'(1 << i));
			wr(`BIS_OFF_LSTAT, 32'h0000_0004);
			settle();
			`CHK(pci_irq_out_lines, 4'h0)
		end
		wr(`BIS_OFF_DCTL, 32'h0000_033F);
		dma_last_pkt <= 1'b0;
		`PULSE(dma_pkt_done, 1'b1)
		settle();
		rd(`BIS_OFF_DSTAT);
		`CHK({dma_fetch_req, rdv[10:8]}, {1'b1, BIS_DMA_FETCH})
		`PULSE(dma_fetch_done, 1'b1)
		settle();
		`CHK({dma_busy, dma_fetch_req}, 2'b10)
		dma_last_pkt <= 1'b1;
		`PULSE(dma_pkt_done, 1'b1)
		settle();
		`CHK(dma_busy, 1'b0)
		wr(`BIS_OFF_DCTL, 32'h0000_023F);
		settle();
		`CHK(dma_busy, 1'b1)
		dma_last_pkt <= 1'b0;
		`PULSE(dma_pkt_done, 1'b1)
		settle();
		`CHK({dma_busy, dma_fetch_req}, 2'b00)
		wr(`BIS_OFF_DCTL, 32'h0000_023F);
		`PULSE(dma_cause, 6'h02)
		settle();
		`CHK({dma_busy, pci_irq_out_lines}, 5'h04)
		wr(`BIS_OFF_DSTAT, 32'h0000_003F);
		wr(`BIS_OFF_LSTAT, 32'h0000_0004);
		settle();
		`CHK(pci_irq_out_lines, 4'h0)
	endtask : t_dma

	task automatic mon_hit(input logic [31:0] a, input logic [1:0] sp,
		input logic [3:0] hit);
		slv_addr  <= a;
		slv_space <= sp;
		`PULSE(slv_valid, 1'b1)
		settle();
		rd(`BIS_OFF_LSTAT);
		`CHK({rdv[10:7], pci_irq_out_lines}, {hit, hit})
		wr(`BIS_OFF_LSTAT, 32'h0000_0780);
		settle();
	endtask : mon_hit

	task automatic t_mon();
		wr(`BIS_OFF_LEN, 32'h0000_0780);
		wr(`BIS_OFF_LMBASE, 32'h1234_5000);
		wr(`BIS_OFF_LMCTL, 32'h0000_0005);
		for (int n = 0; n < 4; n++) begin
			mon_hit(32'h1234_5FE0 | 32'(n << 3), 2'h1, 4'(1 << n));
		end
		mon_hit(32'h1234_6000, 2'h1, 4'h0);
		mon_hit(32'h1234_5000, 2'h2, 4'h0);
		wr(`BIS_OFF_LMCTL, 32'h0000_0001);
		mon_hit(32'h1234_5000, 2'h1, 4'h0);
	endtask : t_mon

	// only errors on posted writes may raise anything
	task automatic t_err();
		wr(`BIS_OFF_LEN, 32'h0000_1800);
		err_posted <= 1'b0;
		`PULSE(pci_abort, 1'b1)
		`PULSE(vme_berr, 1'b1)
		settle();
		rd(`BIS_OFF_LSTAT);
		`CHK(rdv[12:11], 2'b00)
		err_posted <= 1'b1;
		`PULSE(pci_abort, 1'b1)
		`PULSE(vme_berr, 1'b1)
		settle();
		`CHK({pci_irq_out_lines, vme_irq_lines}, 11'h420)
		rd(`BIS_OFF_LSTAT);
		`CHK(rdv[12:11], 2'b11)
		rd(`BIS_OFF_VSTAT);
		`CHK(rdv[6], 1'b1)
		wr(`BIS_OFF_LSTAT, 32'h0000_1800);
		wr(`BIS_OFF_VSTAT, 32'h0000_0040);
		rd(8'hFC);
		settle();
		`CHK({rdv, pci_irq_out_lines, vme_irq_lines}, 43'h0)
	endtask : t_err

	// second reset with the auto-id option off
	task automatic t_nostrap();
		autoid_strap <= 1'b0;
		sys_rst      <= 1'b1;
		#1;
		`CHK({sysfail_assert, crcsr_enable}, 2'b10)
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		`CHK({sysfail_assert, crcsr_enable, vme_irq_lines}, 9'h000)
	endtask : t_nostrap

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		sys_rst = 1'b1;
		{reg_wr, reg_rd, slv_valid, pci_abort, vme_berr} = 5'h00;
		{err_posted, dma_pkt_done, dma_last_pkt, dma_fetch_done} = 4'h0;
		{reg_addr, reg_wdata, slv_addr, slv_space} = 74'h0;
		{mbox_access, dma_cause, handler_en, grant_dly} = 15'h0000;
		autoid_strap = 1'b1;
		fails = 0;
		samples_checked = 0;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		t_autoid();
		t_soft();
		t_own(4'h0);
		t_own(4'h9);
		t_dma();
		t_mon();
		t_err();
		t_nostrap();
		print_verdict();
	end
endmodule : bis_core_bench
